//--- hw/sbcs_pkg.sv
// package: command codes, field positions and reset values of the slot b and common status bank
package sbcs_pkg;
  // command bytes
  localparam logic [7:0] SBCS_CMD_SLOT_B_STATUS = 8'h05;
  localparam logic [7:0] SBCS_CMD_COMMON_STATUS = 8'h06;
  // reset values
  localparam logic [7:0] SBCS_SLOT_B_STATUS_RST = 8'h00;
  localparam logic [7:0] SBCS_COMMON_STATUS_RST = 8'h00;
  // slot b status fields
  localparam int SBCS_B_FAULT_BIT   = 7;
  localparam int SBCS_B_MAIN_BIT    = 6;
  localparam int SBCS_B_AUX_BIT     = 5;
  localparam int SBCS_B_OC_AUX_BIT  = 4;
  localparam int SBCS_B_OC_N12_BIT  = 3;
  localparam int SBCS_B_OC_P12_BIT  = 2;
  localparam int SBCS_B_OC_5V_BIT   = 1;
  localparam int SBCS_B_OC_3V_BIT   = 0;
  localparam int SBCS_OC_W          = 5;
  // common status fields
  localparam int SBCS_C_GP_B_BIT    = 5;
  localparam int SBCS_C_GP_A_BIT    = 4;
  localparam int SBCS_C_MASK_BIT    = 3;
  localparam int SBCS_C_UV_BIT      = 2;
  localparam int SBCS_C_OT_BIT      = 1;
  // overcurrent flags that belong to the main outputs and to the aux output
  localparam logic [4:0] SBCS_OC_MAIN_MASK = 5'h0f;
  localparam logic [4:0] SBCS_OC_AUX_MASK  = 5'h10;
endpackage

//--- hw/sbcs_flag_if.sv
// interface: sticky event flags with write-one-to-clear between the bank and its flag module
`timescale 1ns/1ps
interface sbcs_flag_if #(parameter int W = 5);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic [W-1:0] flags;
  modport bank (output set, output clr, input flags);
  modport flag (input set, input clr, output flags);
endinterface

//--- hw/sbcs_sticky_flags.sv
// sticky flag array: set wins over a clear arriving in the same cycle
`timescale 1ns/1ps
module sbcs_sticky_flags #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // flag port
  sbcs_flag_if.flag  fp
);
  // a width the flag vector cannot take is refused at elaboration
  if (W < 1)
  begin : g_bad_width
    $error("sbcs_sticky_flags: W must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      logic flag_r;
      always_ff @(posedge clk)
      begin
        if (rst)
          flag_r <= 1'b0;
        else if (fp.set[i])
          flag_r <= 1'b1;
        else if (fp.clr[i])
          flag_r <= 1'b0;
      end
      assign fp.flags[i] = flag_r;
    end
  endgenerate
endmodule

//--- hw/sbcs_status_bank.sv
// slot b status and common status registers of a dual-slot hot-plug power controller
`timescale 1ns/1ps
module sbcs_status_bank
  import sbcs_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register access, command-byte addressed
  input  wire logic [7:0]  reg_cmd,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_hit,
  // slot b pins and analog events
  input  wire logic        slot_b_main_on_in,
  input  wire logic        aux_enable_input,
  input  wire logic        slot_b_main_on_state,
  input  wire logic        slot_b_aux_on_state,
  input  wire logic [4:0]  slot_b_oc_event,
  input  wire logic        slot_b_bus_ctrl,
  output logic             slot_b_fault_out_n,
  // common events and pins
  input  wire logic        undervoltage_lockout,
  input  wire logic        main_power_requested,
  input  wire logic        overtemp_trip,
  input  wire logic        slot_a_gp_input,
  input  wire logic        slot_b_gp_input,
  output logic             irq_n
);
  import sbcs_pkg::*;

  // the read image slices the flags off the bottom of the slot b byte and the
  // fault latch splits them by the two masks; refuse a layout they cannot serve
  if (SBCS_OC_W != SBCS_B_OC_AUX_BIT + 1 || SBCS_B_OC_3V_BIT != 0)
  begin : g_bad_oc_field
    $error("sbcs_status_bank: overcurrent field must run from bit 0 to the aux flag");
  end
  if ((SBCS_OC_MAIN_MASK | SBCS_OC_AUX_MASK) != 5'h1f)
  begin : g_bad_oc_cover
    $error("sbcs_status_bank: main and aux masks must cover every overcurrent flag");
  end
  if ((SBCS_OC_MAIN_MASK & SBCS_OC_AUX_MASK) != 5'h00)
  begin : g_bad_oc_overlap
    $error("sbcs_status_bank: main and aux masks must not share a flag");
  end

  // pin synchronisers
  logic [9:0] sync1_r;
  logic [9:0] sync2_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= {slot_b_main_on_in,
                  aux_enable_input,
                  slot_b_main_on_state,
                  slot_b_aux_on_state,
                  undervoltage_lockout,
                  overtemp_trip,
                  slot_a_gp_input,
                  slot_b_gp_input,
                  main_power_requested,
                  slot_b_bus_ctrl};
      sync2_r <= sync1_r;
    end
  end

  logic main_on_s;
  logic aux_en_s;
  logic main_st_s;
  logic aux_st_s;
  logic uv_s;
  logic ot_s;
  logic gpa_s;
  logic gpb_s;
  logic main_req_s;
  logic bus_ctrl_s;
  // the order here must match the order the first stage was loaded in
  assign {main_on_s,
          aux_en_s,
          main_st_s,
          aux_st_s,
          uv_s,
          ot_s,
          gpa_s,
          gpb_s,
          main_req_s,
          bus_ctrl_s} = sync2_r;

  // the analog events are treated as pin levels too; edges make one-shot sets
  // detectors reset low, the idle level of every event, so a reset release sets
  // nothing; an event still held high across a reset does set its flag again
  logic [4:0] oc_s1_r;
  logic [4:0] oc_s2_r;
  logic [4:0] oc_d_r;
  logic       uv_d_r;
  logic       ot_d_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      oc_s1_r <= '0;
      oc_s2_r <= '0;
      oc_d_r  <= '0;
      uv_d_r  <= 1'b0;
      ot_d_r  <= 1'b0;
    end
    else
    begin
      oc_s1_r <= slot_b_oc_event;
      oc_s2_r <= oc_s1_r;
      oc_d_r  <= oc_s2_r;
      uv_d_r  <= uv_s;
      ot_d_r  <= ot_s;
    end
  end

  logic [4:0] oc_rise;
  logic       uv_rise;
  logic       ot_rise;
  assign oc_rise = oc_s2_r & ~oc_d_r;
  assign uv_rise = uv_s & ~uv_d_r;
  assign ot_rise = ot_s & ~ot_d_r;

  logic wr_b;
  logic wr_c;
  assign wr_b = reg_wr && (reg_cmd == SBCS_CMD_SLOT_B_STATUS);
  assign wr_c = reg_wr && (reg_cmd == SBCS_CMD_COMMON_STATUS);

  // overcurrent flags: slot b bits 4..0
  sbcs_flag_if #(.W(SBCS_OC_W)) oc_fp ();
  assign oc_fp.set = oc_rise;
  assign oc_fp.clr = wr_b ? reg_wdata[SBCS_OC_W-1:0] : '0;
  sbcs_sticky_flags #(.W(SBCS_OC_W)) u_oc_flags
  (
    .clk (clk),
    .rst (rst),
    .fp  (oc_fp.flag)
  );

  // common flags: bit 1 overtemperature, bit 0 undervoltage
  sbcs_flag_if #(.W(2)) cm_fp ();
  assign cm_fp.set = {ot_rise, uv_rise & main_req_s};
  assign cm_fp.clr = wr_c ? {reg_wdata[SBCS_C_OT_BIT], reg_wdata[SBCS_C_UV_BIT]} : 2'b00;
  sbcs_sticky_flags #(.W(2)) u_cm_flags
  (
    .clk (clk),
    .rst (rst),
    .fp  (cm_fp.flag)
  );

  // fault latch kept separate from the flags: it clears by the inputs, not by writes
  logic fault_main_r;
  logic fault_aux_r;
  always_ff @(posedge clk)
  begin
    if (rst)
      fault_main_r <= 1'b0;
    else if (bus_ctrl_s)
      fault_main_r <= 1'b0;
    else if (|(oc_rise & SBCS_OC_MAIN_MASK))
      fault_main_r <= 1'b1;
    else if (!main_on_s)
      fault_main_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      fault_aux_r <= 1'b0;
    else if (bus_ctrl_s)
      fault_aux_r <= 1'b0;
    else if (|(oc_rise & SBCS_OC_AUX_MASK))
      fault_aux_r <= 1'b1;
    else if (!aux_en_s)
      fault_aux_r <= 1'b0;
  end

  logic fault;
  assign fault = fault_main_r | fault_aux_r;

  // pin driven from latch only, never from reads
  logic fault_n_r;
  always_ff @(posedge clk)
  begin
    if (rst)
      fault_n_r <= 1'b1;
    else
      fault_n_r <= ~fault;
  end
  assign slot_b_fault_out_n = fault_n_r;

  logic mask_r;
  always_ff @(posedge clk)
  begin
    if (rst)
      mask_r <= SBCS_COMMON_STATUS_RST[SBCS_C_MASK_BIT];
    else if (wr_c)
      mask_r <= reg_wdata[SBCS_C_MASK_BIT];
  end

  // level only, no alert response; host polls
  logic irq_n_r;
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_n_r <= 1'b1;
    else
      irq_n_r <= ~(~mask_r & ((|oc_fp.flags) | (|cm_fp.flags)));
  end
  assign irq_n = irq_n_r;

  // read images
  logic [7:0] slot_b_status;
  logic [7:0] common_status;
  always_comb
  begin
    slot_b_status = SBCS_SLOT_B_STATUS_RST;
    slot_b_status[SBCS_B_FAULT_BIT] = ~fault_n_r;
    slot_b_status[SBCS_B_MAIN_BIT] = main_st_s;
    slot_b_status[SBCS_B_AUX_BIT] = aux_st_s;
    slot_b_status[SBCS_OC_W-1:0] = oc_fp.flags;
  end

  always_comb
  begin
    common_status = SBCS_COMMON_STATUS_RST;
    common_status[SBCS_C_GP_B_BIT] = gpb_s;
    common_status[SBCS_C_GP_A_BIT] = gpa_s;
    common_status[SBCS_C_MASK_BIT] = mask_r;
    common_status[SBCS_C_UV_BIT] = cm_fp.flags[0];
    common_status[SBCS_C_OT_BIT] = cm_fp.flags[1];
  end

  // read data registered; unmapped codes answer zero with reg_hit low
  // a read touches no flag and not the fault pin, so polling has no side effect
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_hit   <= 1'b0;
    end
    else if (reg_rd)
    begin
      unique case (reg_cmd)
        SBCS_CMD_SLOT_B_STATUS:
        begin
          reg_rdata <= slot_b_status;
          reg_hit   <= 1'b1;
        end
        SBCS_CMD_COMMON_STATUS:
        begin
          reg_rdata <= common_status;
          reg_hit   <= 1'b1;
        end
        default:
        begin
          reg_rdata <= 8'h00;
          reg_hit   <= 1'b0;
        end
      endcase
    end
    else
      reg_hit <= 1'b0;
  end
endmodule

//--- bench/sbcs_host.sv
// host model issuing single-byte register accesses
`timescale 1ns/1ps
module sbcs_host (
  // register access
  input  wire logic       clk,
  output logic      [7:0] reg_cmd = 8'h00,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic      [7:0] reg_wdata = 8'h00,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_hit
);
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] q, output logic h);
    @(negedge clk);
    reg_cmd = c;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    q = reg_rdata;
    h = reg_hit;
    {reg_wr, reg_rd} = 2'b00;
    // idle bus shows inverted bytes so a stale value cannot match
    reg_cmd = ~c;
    reg_wdata = ~d;
  endtask
endmodule

//--- bench/sbcs_status_bank_monitor.sv
// port assertions for the status bank
`timescale 1ns/1ps
module sbcs_status_bank_monitor (
  // watched ports
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] reg_cmd,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  input wire logic       slot_b_main_on_in,
  input wire logic       aux_enable_input,
  input wire logic       slot_b_bus_ctrl,
  input wire logic       slot_b_fault_out_n,
  input wire logic       irq_n
);
  logic mapped;
  assign mapped = reg_cmd == 8'h05 || reg_cmd == 8'h06;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  read_hit_a: assert property (reg_rd && mapped |=> reg_hit)
    else $error("no hit");
  unmapped_read_a: assert property (reg_rd && !mapped |=> !reg_hit && !reg_rdata)
    else $error("unmapped answered");
  hit_source_a: assert property (reg_hit |-> $past(reg_rd) && $past(mapped))
    else $error("stray hit");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("rdata moved");
  cs_reserved_a:
    assert property (reg_rd && reg_cmd == 8'h06 |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[0])
    else $error("reserved bits set");
  reset_out_a:
    assert property ($past(rst) |-> irq_n && slot_b_fault_out_n && !reg_hit && !reg_rdata)
    else $error("bad reset level");
  fault_bit_a:
    assert property (reg_rd && reg_cmd == 8'h05 && $stable(slot_b_fault_out_n)
      ##1 $stable(slot_b_fault_out_n) |-> reg_rdata[7] == !slot_b_fault_out_n)
    else $error("fault bit wrong");
  bus_fault_a: assert property (slot_b_bus_ctrl [*5] |-> slot_b_fault_out_n)
    else $error("fault under bus");
  fault_hold_a:
    assert property (!slot_b_fault_out_n && $past(slot_b_main_on_in, 3)
      && $past(aux_enable_input, 3) && !$past(slot_b_bus_ctrl, 3) |=> !slot_b_fault_out_n)
    else $error("fault dropped");
endmodule
bind sbcs_status_bank sbcs_status_bank_monitor mon
(
  .clk                (clk),
  .rst                (rst),
  .reg_cmd            (reg_cmd),
  .reg_rd             (reg_rd),
  .reg_rdata          (reg_rdata),
  .reg_hit            (reg_hit),
  .slot_b_main_on_in  (slot_b_main_on_in),
  .aux_enable_input   (aux_enable_input),
  .slot_b_bus_ctrl    (slot_b_bus_ctrl),
  .slot_b_fault_out_n (slot_b_fault_out_n),
  .irq_n              (irq_n)
);

//--- bench/sbcs_status_bank_tb.sv
// self-checking bench for the status bank
`timescale 1ns/1ps
module sbcs_status_bank_tb;
  localparam logic [7:0] SB = sbcs_pkg::SBCS_CMD_SLOT_B_STATUS;
  localparam logic [7:0] CS = sbcs_pkg::SBCS_CMD_COMMON_STATUS;
  logic clk = '0, rst = '1, slot_b_main_on_in = '0, aux_enable_input = '0, h;
  logic slot_b_main_on_state = '0, slot_b_aux_on_state = '0, slot_b_bus_ctrl = '0;
  logic undervoltage_lockout = '0, main_power_requested = '0, overtemp_trip = '0;
  logic slot_a_gp_input = '0, slot_b_gp_input = '0, reg_wr, reg_rd, reg_hit;
  logic slot_b_fault_out_n, irq_n;
  logic [4:0] slot_b_oc_event = '0;
  logic [7:0] reg_cmd, reg_wdata, reg_rdata, q;
  int n_mismatch = 0, compares = 0, cyc = 0;
  always #12.5 clk = ~clk;
  sbcs_host host
  (
    .clk       (clk),
    .reg_cmd   (reg_cmd),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .reg_hit   (reg_hit)
  );
  sbcs_status_bank uut
  (
    .clk                  (clk),
    .rst                  (rst),
    .reg_cmd              (reg_cmd),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .reg_hit              (reg_hit),
    .slot_b_main_on_in    (slot_b_main_on_in),
    .aux_enable_input     (aux_enable_input),
    .slot_b_main_on_state (slot_b_main_on_state),
    .slot_b_aux_on_state  (slot_b_aux_on_state),
    .slot_b_oc_event      (slot_b_oc_event),
    .slot_b_bus_ctrl      (slot_b_bus_ctrl),
    .slot_b_fault_out_n   (slot_b_fault_out_n),
    .undervoltage_lockout (undervoltage_lockout),
    .main_power_requested (main_power_requested),
    .overtemp_trip        (overtemp_trip),
    .slot_a_gp_input      (slot_a_gp_input),
    .slot_b_gp_input      (slot_b_gp_input),
    .irq_n                (irq_n)
  );
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // flags take several edges through the pin synchronisers, so settle first
  task automatic rdc(input logic [7:0] c, input logic [7:0] e);
    repeat (6) @(negedge clk);
    host.xfer(1'b0, c, 8'h00, q, h);
    chk("rdata", e, q);
    chk("hit", {7'h00, c == SB || c == CS}, {7'h00, h});
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host.xfer(1'b1, c, d, q, h);
  endtask
  task automatic pins(input logic f, input logic i);
    chk("fault_n", {7'h00, f}, {7'h00, slot_b_fault_out_n});
    chk("irq_n", {7'h00, i}, {7'h00, irq_n});
  endtask
  task automatic results;
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    rdc(SB, 8'h00);
    rdc(CS, 8'h00);
    rdc(8'h07, 8'h00);
    pins(1'b1, 1'b1);
    {slot_b_main_on_in, aux_enable_input, slot_b_main_on_state, slot_b_aux_on_state} = '1;
    slot_a_gp_input = 1'b1;
    rdc(SB, 8'h60);
    rdc(CS, 8'h10);
    for (int i = 0; i < 5; i++)
    begin
      slot_b_oc_event[i] = 1'b1;
      rdc(SB, 8'he0 | 8'h01 << i);
      pins(1'b0, 1'b0);
      wr(SB, 8'h01 << i);
      slot_b_oc_event[i] = 1'b0;
      rdc(SB, 8'he0);
      pins(1'b0, 1'b1);
    end
    wr(SB, 8'hff);
    slot_b_main_on_in = 1'b0;
    rdc(SB, 8'he0);
    aux_enable_input = 1'b0;
    rdc(SB, 8'h60);
    pins(1'b1, 1'b1);
    wr(CS, 8'h08);
    {main_power_requested, undervoltage_lockout} = 2'b11;
    rdc(CS, 8'h1c);
    pins(1'b1, 1'b1);
    wr(CS, 8'h04);
    {main_power_requested, undervoltage_lockout, overtemp_trip} = 3'b001;
    rdc(CS, 8'h12);
    pins(1'b1, 1'b0);
    wr(CS, 8'hf2);
    undervoltage_lockout = 1'b1;
    rdc(CS, 8'h10);
    pins(1'b1, 1'b1);
    slot_b_bus_ctrl = 1'b1;
    rdc(SB, 8'h60);
    slot_b_oc_event[0] = 1'b1;
    rdc(SB, 8'h61);
    pins(1'b1, 1'b0);
    wr(8'h07, 8'hff);
    rdc(SB, 8'h61);
    wr(CS, 8'h08);
    {slot_b_main_on_state, slot_b_aux_on_state, slot_b_oc_event} = '0;
    {undervoltage_lockout, overtemp_trip, slot_b_gp_input} = 3'b001;
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    pins(1'b1, 1'b1);
    rdc(SB, 8'h00);
    rdc(CS, 8'h30);
    results();
  end
endmodule
